// File: design/interval_timer_pkg.sv
// Purpose: constants and types for the periodic interval interrupt timer
// Assumes: 8-bit special-function register port, 200 MHz system clock
// Notes:   base tick of 95 us; lower stage divides it by 20/19 into 100 us
package interval_timer_pkg;

	localparam logic [7:0]  CTRL_ADDR       = 8'h9c;
	localparam logic [7:0]  CTRL_RESET      = 8'h00;
	localparam int          FLAG_BIT        = 7;
	localparam int          ENA_BIT         = 6;
	localparam int          CLR_BIT         = 5;
	localparam int          DIV_MSB         = 2;
	localparam int          DIV_LSB         = 0;

	localparam int          CLOCK_PERIOD_PS = 5000;
	// base tick period: 100 us times 19/20
	localparam int          BASE_TICK_NS    = 95000;
	localparam int          BASE_TICK_CYC   = (BASE_TICK_NS * 1000) / CLOCK_PERIOD_PS;
	localparam int          BASE_CNT_W      = 16;

	// lower stage: 19 of every 20 base ticks give a 100 us step
	localparam logic [4:0]  FRAC_MOD_LAST   = 5'h13;
	localparam logic [2:0]  UPPER_MIN_DIV   = 3'h3;

	// upper stage terminal counts in 200 us steps, by interval select
	localparam logic [4:0]  UPPER_400US     = 5'h02;
	localparam logic [4:0]  UPPER_800US     = 5'h04;
	localparam logic [4:0]  UPPER_1MS       = 5'h05;
	localparam logic [4:0]  UPPER_2MS       = 5'h0a;
	localparam logic [4:0]  UPPER_5MS       = 5'h19;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic [BASE_CNT_W-1:0] base_cnt;
		logic [4:0]            frac;
		logic                  half;
		logic [4:0]            upper;
		logic                  flag;
		logic                  ena;
		logic [2:0]            div;
		logic [7:0]            rdata;
		logic                  irq;
	} timer_state_t;

endpackage : interval_timer_pkg

// File: design/interval_timer.sv
// Purpose: periodic interval interrupt timer behind one 8-bit control register
// Assumes: SFR port inputs synchronous to CLOCK; one access per cycle
// Notes:   base tick clear comes from another register as a plain input
//
// Operation
// [R1] interval elapse sets bit 7 flag; only a software zero write or reset clears it
// [R2] enable bit 6 resumes base tick and lower stage from held values
// [R3] upper stage runs only when enabled and interval select is 3 or more
// [R4] writing 1 to bit 5 clears the pulse generator, not the base tick
// [R5] reserved bits 4:3 read zero and ignore writes
// [R6] select 0 disables; 1..7 give 100us,200us,400us,800us,1ms,2ms,5ms
// [R7] select 1 derives 100us from the base tick with a 20/19 divider
// [R8] interrupt request follows the interval flag level
`timescale 1ns/1ps
module interval_timer #(
	parameter int BASE_TICK_CYCLES = interval_timer_pkg::BASE_TICK_CYC
) (
	input  wire logic                         CLOCK,            // system clock, 200 MHz
	input  wire logic                         RST_N,            // synchronous reset, active low
	input  wire interval_timer_pkg::sfr_req_t SFR_REQ,          // register address, strobes, write data
	input  wire logic                         BASE_TICK_CLEAR,  // clears the base tick counter
	output logic [7:0]                        SFR_RDATA,        // read data, valid the cycle after rd
	output logic                              IRQ               // interval interrupt request
);
	import interval_timer_pkg::*;

	timer_state_t s_r;
	timer_state_t s_nxt;
	logic         base_tick;
	logic         lower_pulse;
	logic         interval_evt;
	logic         ctrl_wr;
	logic         ctrl_rd;
	logic         pulse_clr;

	localparam logic [BASE_CNT_W-1:0] TICK_LAST = BASE_CNT_W'(BASE_TICK_CYCLES - 1);

	function automatic logic [4:0] upper_last(input logic [2:0] sel);
		unique case (sel)
			3'h3:    upper_last = UPPER_400US - 5'h01;
			3'h4:    upper_last = UPPER_800US - 5'h01;
			3'h5:    upper_last = UPPER_1MS - 5'h01;
			3'h6:    upper_last = UPPER_2MS - 5'h01;
			default: upper_last = UPPER_5MS - 5'h01;
		endcase
	endfunction : upper_last

	function automatic logic ctrl_hit(input logic [7:0] addr);
		ctrl_hit = (addr == CTRL_ADDR);
	endfunction : ctrl_hit

	always_comb begin
		s_nxt        = s_r;
		ctrl_wr      = SFR_REQ.wr && ctrl_hit(SFR_REQ.addr);
		ctrl_rd      = SFR_REQ.rd && ctrl_hit(SFR_REQ.addr);
		pulse_clr    = ctrl_wr && SFR_REQ.wdata[CLR_BIT];
		base_tick    = 1'b0;
		lower_pulse  = 1'b0;
		interval_evt = 1'b0;

		// base tick clears on BASE_TICK_CLEAR, else free-runs while enabled and holds otherwise
		if (BASE_TICK_CLEAR) begin
			s_nxt.base_cnt = '0;
		end else if (s_r.ena) begin  // R2
			if (s_r.base_cnt == TICK_LAST) begin
				s_nxt.base_cnt = '0;
				base_tick      = 1'b1;
			end else begin
				s_nxt.base_cnt = s_r.base_cnt + 1'b1;
			end
		end

		// lower stage: drop one base tick in twenty
		if (base_tick) begin  // R2
			s_nxt.frac  = (s_r.frac == FRAC_MOD_LAST) ? 5'h00 : s_r.frac + 5'h01;  // R7
			lower_pulse = (s_r.frac != FRAC_MOD_LAST);  // R7
			if (lower_pulse)
				s_nxt.half = ~s_r.half;
		end

		// upper stage counts 200 us steps when enabled and select is 3 or more
		if (lower_pulse && s_r.half && s_r.ena && s_r.div >= UPPER_MIN_DIV) begin  // R3
			if (s_r.upper >= upper_last(s_r.div)) begin
				s_nxt.upper  = 5'h00;
				interval_evt = 1'b1;  // R6
			end else begin
				s_nxt.upper = s_r.upper + 5'h01;
			end
		end

		if (s_r.div == 3'h1)
			interval_evt = lower_pulse;  // R6 R7
		else if (s_r.div == 3'h2)
			interval_evt = lower_pulse && s_r.half;  // R6

		// register write; the clear bit is not stored
		if (ctrl_wr) begin
			s_nxt.flag = SFR_REQ.wdata[FLAG_BIT];
			s_nxt.ena  = SFR_REQ.wdata[ENA_BIT];
			s_nxt.div  = SFR_REQ.wdata[DIV_MSB:DIV_LSB];  // R5
		end
		if (pulse_clr) begin  // R4
			s_nxt.frac  = 5'h00;
			s_nxt.half  = 1'b0;
			s_nxt.upper = 5'h00;
		end
		// an elapse in the same cycle as a zero write still sets the flag
		if (interval_evt)
			s_nxt.flag = 1'b1;  // R1

		s_nxt.irq = s_nxt.flag;  // R8

		if (ctrl_rd)
			s_nxt.rdata = {s_r.flag, s_r.ena, 3'b000, s_r.div};  // R5
		else
			s_nxt.rdata = 8'h00;
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign SFR_RDATA = s_r.rdata;
	assign IRQ       = s_r.irq;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	sequence s_zero_flag_wr;
		ctrl_wr && !SFR_REQ.wdata[FLAG_BIT];
	endsequence

	sequence s_held_idle;
		!s_r.ena && !BASE_TICK_CLEAR;
	endsequence

	sequence s_resume;
		s_held_idle ##1 s_r.ena;
	endsequence

	a_flag_sticky: assert property (s_r.flag && !ctrl_wr |=> s_r.flag) // R1
		else $error("interval flag dropped without a software write");

	a_flag_set: assert property (interval_evt |=> s_r.flag ##0 IRQ) // R1
		else $error("interval elapse did not set the flag");

	a_tick_hold: assert property (s_held_idle ##1 s_held_idle |=> $stable(s_r.base_cnt)) // R2
		else $error("base tick moved while disabled");

	a_upper_gate: assert property ((s_r.div < UPPER_MIN_DIV || !s_r.ena) && !pulse_clr |=> $stable(s_r.upper)) // R3
		else $error("upper stage ran below select 3 or while disabled");

	a_gen_clear: assert property (pulse_clr && !s_r.ena && !BASE_TICK_CLEAR // R4
		|=> s_r.frac == 5'h00 && s_r.upper == 5'h00 && !s_r.half && $stable(s_r.base_cnt))
		else $error("pulse generator clear wrong");

	a_reserved_zero: assert property (SFR_RDATA[5:3] == 3'b000) // R5
		else $error("reserved or write-only bits read nonzero");

	a_div0_quiet: assert property (s_r.div == 3'h0 ##0 s_zero_flag_wr |=> !s_r.flag) // R6
		else $error("flag set with interval generation disabled");

	a_frac_drop: assert property (base_tick && s_r.frac == FRAC_MOD_LAST |-> !lower_pulse ##1 s_r.frac == 5'h00) // R7
		else $error("20/19 divider did not drop a tick");

	a_irq_level: assert property (##1 IRQ == s_r.flag) // R8
		else $error("interrupt request differs from flag");

	// reads and refused accesses
	a_rd_data: assert property (ctrl_rd // R5
		|=> SFR_RDATA == {$past(s_r.flag), $past(s_r.ena), 3'h0, $past(s_r.div)})
		else $error("control register read data wrong");

	a_rd_idle: assert property (!ctrl_rd |=> SFR_RDATA == 8'h00) // R5
		else $error("read data shown without a control register read");

	// base tick and flag set priority
	a_tick_range: assert property (s_r.base_cnt <= TICK_LAST) // R2
		else $error("base tick counter past its terminal count");

	a_ena_gate: assert property (!s_r.ena |-> !base_tick) // R2
		else $error("base tick while disabled");

	a_tick_resume: assert property (s_resume ##0 (!BASE_TICK_CLEAR && s_r.base_cnt != TICK_LAST) // R2
		|=> s_r.base_cnt == $past(s_r.base_cnt, 2) + 1'b1)
		else $error("base tick restarted instead of resuming");

	a_tick_clear: assert property (BASE_TICK_CLEAR |=> s_r.base_cnt == '0) // R4
		else $error("base tick clear input ignored");

	a_clr_keeps_tick: assert property (pulse_clr && s_r.ena && !BASE_TICK_CLEAR && s_r.base_cnt != TICK_LAST // R4
		|=> s_r.base_cnt == $past(s_r.base_cnt) + 1'b1)
		else $error("pulse generator clear disturbed the base tick");

	a_set_wins: assert property (interval_evt ##0 s_zero_flag_wr |=> IRQ) // R1
		else $error("zero write beat an interval elapse in the same cycle");

	// lower stage
	a_pulse_on_tick: assert property (lower_pulse |-> base_tick) // R7
		else $error("lower pulse without a base tick");

	a_frac_range: assert property (s_r.frac <= FRAC_MOD_LAST) // R7
		else $error("20/19 divider count out of range");

	a_frac_step: assert property (base_tick && !pulse_clr && s_r.frac != FRAC_MOD_LAST // R7
		|-> lower_pulse ##1 s_r.frac == $past(s_r.frac) + 5'h01)
		else $error("20/19 divider did not pass a tick");

	a_half_toggle: assert property (lower_pulse && !pulse_clr |=> s_r.half != $past(s_r.half)) // R2
		else $error("200 us half step did not toggle");

	// interval select
	a_div_off: assert property (s_r.div == 3'h0 |-> !interval_evt) // R6
		else $error("interval elapse with generation disabled");

	a_div1_rate: assert property (s_r.div == 3'h1 && lower_pulse |-> interval_evt) // R6
		else $error("100 us interval missed");

	a_div2_rate: assert property (s_r.div == 3'h2 && lower_pulse |-> interval_evt == s_r.half) // R6
		else $error("200 us interval wrong");

	a_upper_step: assert property (s_r.ena && s_r.div >= UPPER_MIN_DIV && lower_pulse && s_r.half && !pulse_clr // R3
		|=> s_r.upper != $past(s_r.upper))
		else $error("upper stage did not step");

endmodule : interval_timer

// File: tb/tb_top.sv
// Purpose: self-checking bench for interval_timer
// Assumes: base tick shortened to 4 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
module tb_top;
	import interval_timer_pkg::*;
	localparam int TICK = 4;
	logic        clock      = 1'b0;
	logic        rst_n      = 1'b0;
	sfr_req_t    req        = '0;
	logic        tick_clear = 1'b0;
	logic [7:0]  rdata;
	logic        irq;
	int          fails      = 0;
	int          cmp_count  = 0;
	int          cyc;
	int          lo;
	int          hi;
	int          steps [7]  = '{1, 2, 4, 8, 10, 20, 50};
	logic [15:0] rows [5]   = '{16'h1f07, 16'h2000, 16'h5b43, 16'h8080, 16'h0000};

	interval_timer #(.BASE_TICK_CYCLES(TICK)) u_interval_timer (.CLOCK(clock), .RST_N(rst_n), .SFR_REQ(req),
		.BASE_TICK_CLEAR(tick_clear), .SFR_RDATA(rdata), .IRQ(irq));

	initial forever #2.5 clock = ~clock;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one access cycle, then one idle cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(negedge clock);
		req = '0;
		@(negedge clock);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(negedge clock);
		req = '0;
		chk(rdata, exp);
		@(negedge clock);
	endtask : rd

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (16) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		chk({7'h00, irq}, 8'h00);
		rd(CTRL_ADDR, CTRL_RESET);
		foreach (rows[i]) begin
			wr(CTRL_ADDR, rows[i][15:8]);
			rd(CTRL_ADDR, rows[i][7:0]);
		end
		wr(8'h9d, 8'h47);
		rd(8'h9d, 8'h00);
		rd(CTRL_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h40);
		repeat (300) @(negedge clock);
		chk({7'h00, irq}, 8'h00);
		for (int d = 1; d < 8; d++) begin
			// stop, clear pulse generator and flag, then zero the base tick
			wr(CTRL_ADDR, 8'h20 | 8'(d));
			tick_clear = 1'b1;
			@(negedge clock);
			tick_clear = 1'b0;
			wr(CTRL_ADDR, 8'h40 | 8'(d));
			cyc = 0;
			while (irq !== 1'b1 && cyc < 400) begin
				@(negedge clock);
				cyc++;
			end
			// ticks needed, every twentieth one dropped; the count starts one cycle late
			lo = (steps[d-1] + steps[d-1] / 19) * TICK - 1;
			hi = lo;
			chk(8'(cyc >= lo && cyc <= hi), 8'h01);
			repeat (20) @(negedge clock);
			chk({7'h00, irq}, 8'h01);
			rd(CTRL_ADDR, 8'hc0 | 8'(d));
			wr(CTRL_ADDR, 8'(d));
			chk({7'h00, irq}, 8'h00);
		end
		// an elapse in the cycle of a zero write keeps the flag
		wr(CTRL_ADDR, 8'h21);
		tick_clear = 1'b1;
		@(negedge clock);
		tick_clear = 1'b0;
		wr(CTRL_ADDR, 8'h41);
		repeat (2) @(negedge clock);
		wr(CTRL_ADDR, 8'h41);
		chk({7'h00, irq}, 8'h01);
		// pause after two of four tick cycles, then resume where it stopped
		wr(CTRL_ADDR, 8'h21);
		tick_clear = 1'b1;
		@(negedge clock);
		tick_clear = 1'b0;
		wr(CTRL_ADDR, 8'h41);
		wr(CTRL_ADDR, 8'h01);
		repeat (10) @(negedge clock);
		chk({7'h00, irq}, 8'h00);
		wr(CTRL_ADDR, 8'h41);
		chk({7'h00, irq}, 8'h00);
		@(negedge clock);
		chk({7'h00, irq}, 8'h01);
		// reset in mid-run drops flag and register
		rst_n = 1'b0;
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		@(negedge clock);
		chk({7'h00, irq}, 8'h00);
		rd(CTRL_ADDR, CTRL_RESET);
		wrap_up();
	end

	initial begin
		#100000;
		fails++;
		wrap_up();
	end
endmodule : tb_top
